//--- pkg/icr_pkg.sv
// Purpose: constants for the channel register map of the i2c controller
// Assumes: 8-bit host bus, one clock, synchronous active-high reset
// Notes: used by the register map only; its sub-blocks take parameters instead
// Operation
// RL1: table, setup, tally and buffer indices step after every host access; the code does not step on dropped writes or on host tally writes
// RL2: buffer pointer is set from buffer select and byte offset
// RL3: command register bits clear buffer pointer and auto indices
// RL4: top bits 00/01/10 read 64-entry status of channel 0/1/2
// RL5: page C holds the sixteen channel 0 registers in order
// RL6: table 64, setup 65, tally 64 bytes, each behind one address
// RL7: while active only some registers accept writes; host keeps off others
// RL8: reset values 01h, 5Eh, 3Fh, 92h, all others zero
// RL9: channel data buffer is 4352 bytes, apart from table and setup
// RL10: host writes buffer only when idle, reads after valid status; the code accepts buffer writes while active too
// RL11: protected writes while active are dropped without any effect
package icr_pkg;
  localparam int NUM_CH = 3;
  localparam int BUF_DEPTH = 4352;
  localparam int BUF_AW = 13;
  localparam int TBL_DEPTH = 64;
  localparam int CFG_DEPTH = 65;
  localparam int TALLY_DEPTH = 64;
  localparam int STAT_DEPTH = 64;
  localparam int IDX_AW = 7;
  localparam int STAT_AW = 6;
  // address decode
  localparam logic [1:0] STAT_PAGE_NONE = 2'h3;
  localparam logic [3:0] CH0_PAGE = 4'hC;
  localparam logic [3:0] OFS_CMD = 4'h0;
  localparam logic [3:0] OFS_STATE = 4'h1;
  localparam logic [3:0] OFS_IRQ = 4'h2;
  localparam logic [3:0] OFS_TBL = 4'h3;
  localparam logic [3:0] OFS_CFG = 4'h4;
  localparam logic [3:0] OFS_BUF = 4'h5;
  localparam logic [3:0] OFS_SEL = 4'h6;
  localparam logic [3:0] OFS_OFS = 4'h7;
  localparam logic [3:0] OFS_TALLY = 4'h8;
  localparam logic [3:0] OFS_RPT = 4'h9;
  localparam logic [3:0] OFS_INTV = 4'hA;
  localparam logic [3:0] OFS_CLK_LO = 4'hB;
  localparam logic [3:0] OFS_CLK_HI = 4'hC;
  localparam logic [3:0] OFS_MODE = 4'hD;
  localparam logic [3:0] OFS_STALL = 4'hE;
  localparam logic [3:0] OFS_SRST = 4'hF;
  // reset values
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_RPT_TOTAL = 8'h01;
  localparam logic [7:0] RST_SCL_LO = 8'h5E;
  localparam logic [7:0] RST_SCL_HI = 8'h3F;
  localparam logic [7:0] RST_MODE = 8'h92;
  // command field positions
  localparam int CMD_BPTR_CLR_BIT = 6;
  localparam int CMD_IDX_CLR_BIT = 7;
  localparam logic [7:0] CMD_CLR_MASK = 8'h3F;
  // setup entry holding the transaction total
  localparam logic [IDX_AW-1:0] CFG_TOTAL_IDX = 7'h00;
  // buffer pointer: select scaled by sixteen plus offset
  localparam logic [3:0] SEL_PAD = 4'h0;
  localparam logic [BUF_AW-1:0] BUF_LAST = 13'h10FF;
  localparam logic [BUF_AW-1:0] BUF_START = 13'h0000;
  localparam logic [BUF_AW-1:0] BUF_ONE = 13'h0001;
endpackage

//--- logic/icr_wrap_index.sv
// Purpose: auto-increment index that wraps after its last entry
// Assumes: clear has priority over increment
// Notes: state frozen while the clock enable is low
`timescale 1ns/1ns
`default_nettype none
module icr_wrap_index #(
  parameter int DEPTH = 64,
  parameter int W = 7
) (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic clk_en_i,
  input wire logic clr_i,
  input wire logic inc_i,
  output logic [W-1:0] idx_o
);
  typedef struct packed {
    logic [W-1:0] idx;
  } icr_idx_st_t;
  localparam logic [W-1:0] LAST = W'(DEPTH - 1);
  localparam logic [W-1:0] ZERO = '0;
  icr_idx_st_t q, d;

  always_comb begin
    d = q;
    if (clr_i) begin
      d.idx = ZERO;
    end else if (inc_i) begin
      d.idx = (q.idx == LAST) ? ZERO : q.idx + W'(1);
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      q <= '0;
    end else if (clk_en_i) begin
      q <= d;
    end
  end

  assign idx_o = q.idx;
endmodule // icr_wrap_index
`default_nettype wire

//--- logic/icr_byte_array.sv
// Purpose: byte array in flip-flops, one write port, one read port
// Assumes: read is combinational from the stored state
// Notes: every entry clears to zero on reset
`timescale 1ns/1ns
`default_nettype none
module icr_byte_array #(
  parameter int DEPTH = 64,
  parameter int AW = 6
) (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic clk_en_i,
  input wire logic we_i,
  input wire logic [AW-1:0] waddr_i,
  input wire logic [7:0] wdata_i,
  input wire logic [AW-1:0] raddr_i,
  output logic [7:0] rdata_o
);
  typedef struct packed {
    logic [DEPTH-1:0][7:0] mem;
  } icr_arr_st_t;
  icr_arr_st_t q, d;

  always_comb begin
    d = q;
    if (we_i) begin
      d.mem[waddr_i] = wdata_i;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      q <= '0;
    end else if (clk_en_i) begin
      q <= d;
    end
  end

  assign rdata_o = q.mem[raddr_i];
endmodule // icr_byte_array
`default_nettype wire

//--- logic/icr_regmap.sv
// Purpose: host register map of channel 0 plus status of all channels
// Assumes: host strobes are one-cycle pulses synchronous to sys_clk_i
// Notes: read data appears on the edge that takes the read strobe
`timescale 1ns/1ns
`default_nettype none
module icr_regmap (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic clk_en_i,
  input wire logic [7:0] host_addr_i,
  input wire logic host_wr_i,
  input wire logic host_rd_i,
  input wire logic [7:0] host_wdata_i,
  output logic [7:0] host_rdata_o,
  input wire logic ch_active_i,
  input wire logic [7:0] ch_state_i,
  input wire logic stat_wr_i,
  input wire logic [1:0] stat_ch_i,
  input wire logic [5:0] stat_idx_i,
  input wire logic [7:0] stat_val_i,
  input wire logic tally_wr_i,
  input wire logic [5:0] tally_idx_i,
  input wire logic [7:0] tally_val_i,
  output logic [7:0] cmd_o,
  output logic [7:0] irq_gate_o,
  output logic [7:0] repeat_total_o,
  output logic [7:0] repeat_interval_o,
  output logic [7:0] scl_low_o,
  output logic [7:0] scl_high_o,
  output logic [7:0] mode_o,
  output logic [7:0] stall_limit_o,
  output logic [7:0] soft_reset_o
);
  typedef struct packed {
    logic [7:0] cmd;
    logic [7:0] irq_gate;
    logic [7:0] sel;
    logic [7:0] ofs;
    logic [7:0] rpt_total;
    logic [7:0] rpt_intv;
    logic [7:0] scl_lo;
    logic [7:0] scl_hi;
    logic [7:0] mode;
    logic [7:0] stall;
    logic [7:0] srst;
    logic [7:0] state;
    logic [7:0] rdata;
    logic [icr_pkg::BUF_AW-1:0] ptr;
  } icr_top_st_t;

  // ----------------------------------------------------------------
  // reset image
  // ----------------------------------------------------------------
  // RL8: reset values
  localparam icr_top_st_t RST_ST = '{
    cmd: icr_pkg::RST_ZERO, irq_gate: icr_pkg::RST_ZERO,
    sel: icr_pkg::RST_ZERO, ofs: icr_pkg::RST_ZERO,
    rpt_total: icr_pkg::RST_RPT_TOTAL, rpt_intv: icr_pkg::RST_ZERO,
    scl_lo: icr_pkg::RST_SCL_LO, scl_hi: icr_pkg::RST_SCL_HI,
    mode: icr_pkg::RST_MODE, stall: icr_pkg::RST_ZERO,
    srst: icr_pkg::RST_ZERO, state: icr_pkg::RST_ZERO,
    rdata: icr_pkg::RST_ZERO, ptr: icr_pkg::BUF_START};

  icr_top_st_t q, d;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  logic wr, rd, is_stat, is_ch0, lock;
  logic [3:0] rofs;
  logic hit_tbl, hit_cfg, hit_buf, hit_tally;
  logic tbl_we, cfg_we, buf_we, idx_clr;
  logic tbl_inc, cfg_inc, tally_inc;
  logic [icr_pkg::IDX_AW-1:0] tbl_idx, cfg_idx, tally_idx;
  logic [7:0] tbl_rd, cfg_rd, buf_rd, tally_rd, rd_val;
  logic [icr_pkg::NUM_CH-1:0][7:0] stat_rd;

  // a write in the same cycle as a read takes the bus; the read is dropped
  assign wr = host_wr_i;
  assign rd = host_rd_i & ~host_wr_i;
  // RL4: status page decode
  assign is_stat = host_addr_i[7:6] != icr_pkg::STAT_PAGE_NONE;
  // RL5: channel 0 page decode
  assign is_ch0 = host_addr_i[7:4] == icr_pkg::CH0_PAGE;
  assign rofs = host_addr_i[3:0];
  assign lock = ch_active_i;
  assign hit_tbl = is_ch0 && rofs == icr_pkg::OFS_TBL;
  assign hit_cfg = is_ch0 && rofs == icr_pkg::OFS_CFG;
  assign hit_buf = is_ch0 && rofs == icr_pkg::OFS_BUF;
  assign hit_tally = is_ch0 && rofs == icr_pkg::OFS_TALLY;

  // RL7: writes allowed while active
  assign tbl_we = wr && hit_tbl && !lock;
  assign cfg_we = wr && hit_cfg
    && (!lock || cfg_idx == icr_pkg::CFG_TOTAL_IDX);
  assign buf_we = wr && hit_buf;

  // RL1: auto-increment on access
  // a dropped write does not move the index either
  assign tbl_inc = tbl_we || (rd && hit_tbl);
  assign cfg_inc = cfg_we || (rd && hit_cfg);
  assign tally_inc = rd && hit_tally;
  // RL3: index clear from command
  assign idx_clr = wr && is_ch0 && rofs == icr_pkg::OFS_CMD
    && host_wdata_i[icr_pkg::CMD_IDX_CLR_BIT];

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  // RL6: table index
  icr_wrap_index #(.DEPTH(icr_pkg::TBL_DEPTH), .W(icr_pkg::IDX_AW)) u_tbl_ix (
    .sys_clk_i(sys_clk_i), .reset_i(reset_i), .clk_en_i(clk_en_i),
    .clr_i(idx_clr), .inc_i(tbl_inc), .idx_o(tbl_idx));
  // RL6: setup index
  icr_wrap_index #(.DEPTH(icr_pkg::CFG_DEPTH), .W(icr_pkg::IDX_AW)) u_cfg_ix (
    .sys_clk_i(sys_clk_i), .reset_i(reset_i), .clk_en_i(clk_en_i),
    .clr_i(idx_clr), .inc_i(cfg_inc), .idx_o(cfg_idx));
  // RL6: tally index
  icr_wrap_index #(.DEPTH(icr_pkg::TALLY_DEPTH), .W(icr_pkg::IDX_AW))
    u_tal_ix (
    .sys_clk_i(sys_clk_i), .reset_i(reset_i), .clk_en_i(clk_en_i),
    .clr_i(idx_clr), .inc_i(tally_inc), .idx_o(tally_idx));

  icr_byte_array #(.DEPTH(icr_pkg::TBL_DEPTH), .AW(icr_pkg::STAT_AW))
    u_tbl (
    .sys_clk_i(sys_clk_i), .reset_i(reset_i), .clk_en_i(clk_en_i),
    .we_i(tbl_we), .waddr_i(tbl_idx[icr_pkg::STAT_AW-1:0]),
    .wdata_i(host_wdata_i), .raddr_i(tbl_idx[icr_pkg::STAT_AW-1:0]),
    .rdata_o(tbl_rd));
  icr_byte_array #(.DEPTH(icr_pkg::CFG_DEPTH), .AW(icr_pkg::IDX_AW))
    u_cfg (
    .sys_clk_i(sys_clk_i), .reset_i(reset_i), .clk_en_i(clk_en_i),
    .we_i(cfg_we), .waddr_i(cfg_idx), .wdata_i(host_wdata_i),
    .raddr_i(cfg_idx), .rdata_o(cfg_rd));
  // tally is written only by the sequencer; host side is read-only
  icr_byte_array #(.DEPTH(icr_pkg::TALLY_DEPTH), .AW(icr_pkg::STAT_AW))
    u_tally (
    .sys_clk_i(sys_clk_i), .reset_i(reset_i), .clk_en_i(clk_en_i),
    .we_i(tally_wr_i), .waddr_i(tally_idx_i), .wdata_i(tally_val_i),
    .raddr_i(tally_idx[icr_pkg::STAT_AW-1:0]), .rdata_o(tally_rd));
  // RL9: data buffer
  icr_byte_array #(.DEPTH(icr_pkg::BUF_DEPTH), .AW(icr_pkg::BUF_AW))
    u_buf (
    .sys_clk_i(sys_clk_i), .reset_i(reset_i), .clk_en_i(clk_en_i),
    .we_i(buf_we), .waddr_i(q.ptr), .wdata_i(host_wdata_i),
    .raddr_i(q.ptr), .rdata_o(buf_rd));

  // RL4: status arrays, one per channel
  for (genvar g = 0; g < icr_pkg::NUM_CH; g++) begin : g_stat
    icr_byte_array #(.DEPTH(icr_pkg::STAT_DEPTH), .AW(icr_pkg::STAT_AW))
      u_stat (
      .sys_clk_i(sys_clk_i), .reset_i(reset_i), .clk_en_i(clk_en_i),
      .we_i(stat_wr_i && stat_ch_i == 2'(g)), .waddr_i(stat_idx_i),
      .wdata_i(stat_val_i), .raddr_i(host_addr_i[icr_pkg::STAT_AW-1:0]),
      .rdata_o(stat_rd[g]));
  end

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  // RL5: register order on the channel page
  always_comb begin
    rd_val = icr_pkg::RST_ZERO;
    if (is_stat) begin
      rd_val = stat_rd[host_addr_i[7:6]];
    end else if (is_ch0) begin
      unique case (rofs)
        icr_pkg::OFS_CMD: rd_val = q.cmd;
        icr_pkg::OFS_STATE: rd_val = q.state;
        icr_pkg::OFS_IRQ: rd_val = q.irq_gate;
        icr_pkg::OFS_TBL: rd_val = tbl_rd;
        icr_pkg::OFS_CFG: rd_val = cfg_rd;
        icr_pkg::OFS_BUF: rd_val = buf_rd;
        icr_pkg::OFS_SEL: rd_val = q.sel;
        icr_pkg::OFS_OFS: rd_val = q.ofs;
        icr_pkg::OFS_TALLY: rd_val = tally_rd;
        icr_pkg::OFS_RPT: rd_val = q.rpt_total;
        icr_pkg::OFS_INTV: rd_val = q.rpt_intv;
        icr_pkg::OFS_CLK_LO: rd_val = q.scl_lo;
        icr_pkg::OFS_CLK_HI: rd_val = q.scl_hi;
        icr_pkg::OFS_MODE: rd_val = q.mode;
        icr_pkg::OFS_STALL: rd_val = q.stall;
        icr_pkg::OFS_SRST: rd_val = q.srst;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // register next state
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    d.state = ch_state_i;
    if (rd) begin
      d.rdata = rd_val;
    end
    // RL1: buffer window steps after each access
    if ((wr || rd) && hit_buf) begin
      d.ptr = (q.ptr == icr_pkg::BUF_LAST) ? icr_pkg::BUF_START
        : q.ptr + icr_pkg::BUF_ONE;
    end
    if (wr && is_ch0) begin
      unique case (rofs)
        // pointer clear bits act once and never read back set
        icr_pkg::OFS_CMD: d.cmd = host_wdata_i & icr_pkg::CMD_CLR_MASK;
        icr_pkg::OFS_IRQ: d.irq_gate = host_wdata_i;
        // RL2: pointer from select and offset
        icr_pkg::OFS_SEL: begin
          d.sel = host_wdata_i;
          d.ptr = {1'b0, host_wdata_i, icr_pkg::SEL_PAD} + {5'h00, q.ofs};
        end
        icr_pkg::OFS_OFS: begin
          d.ofs = host_wdata_i;
          d.ptr = {1'b0, q.sel, icr_pkg::SEL_PAD} + {5'h00, host_wdata_i};
        end
        icr_pkg::OFS_SRST: d.srst = host_wdata_i;
        default: begin
          // RL11: protected writes dropped while active
          if (!lock) begin
            unique case (rofs)
              icr_pkg::OFS_RPT: d.rpt_total = host_wdata_i;
              icr_pkg::OFS_INTV: d.rpt_intv = host_wdata_i;
              icr_pkg::OFS_CLK_LO: d.scl_lo = host_wdata_i;
              icr_pkg::OFS_CLK_HI: d.scl_hi = host_wdata_i;
              icr_pkg::OFS_MODE: d.mode = host_wdata_i;
              icr_pkg::OFS_STALL: d.stall = host_wdata_i;
              default: d.mode = q.mode;
            endcase
          end
        end
      endcase
      // RL3: buffer pointer clear from command
      if (rofs == icr_pkg::OFS_CMD
          && host_wdata_i[icr_pkg::CMD_BPTR_CLR_BIT]) begin
        d.ptr = icr_pkg::BUF_START;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      q <= RST_ST;
    end else if (clk_en_i) begin
      q <= d;
    end
  end

  assign host_rdata_o = q.rdata;
  assign cmd_o = q.cmd;
  assign irq_gate_o = q.irq_gate;
  assign repeat_total_o = q.rpt_total;
  assign repeat_interval_o = q.rpt_intv;
  assign scl_low_o = q.scl_lo;
  assign scl_high_o = q.scl_hi;
  assign mode_o = q.mode;
  assign stall_limit_o = q.stall;
  assign soft_reset_o = q.srst;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);

  a_tbl_idx_step: assert property ( // RL1
    clk_en_i && tbl_inc && !idx_clr && tbl_idx != 7'd63
    |=> tbl_idx == $past(tbl_idx) + 7'd1)
    else $error("table index did not step");
  a_ptr_load: assert property ( // RL2
    clk_en_i && wr && is_ch0 && rofs == icr_pkg::OFS_OFS
    |=> q.ptr == {1'b0, q.sel, 4'h0} + {5'h00, q.ofs})
    else $error("buffer pointer not loaded from select and offset");
  a_ptr_clear: assert property ( // RL3
    clk_en_i && wr && is_ch0 && rofs == icr_pkg::OFS_CMD
    && host_wdata_i[icr_pkg::CMD_BPTR_CLR_BIT] |=> q.ptr == 13'h0000)
    else $error("buffer pointer not cleared");
  a_idx_clear: assert property ( // RL3
    clk_en_i && idx_clr
    |=> tbl_idx == 7'd0 && cfg_idx == 7'd0 && tally_idx == 7'd0)
    else $error("auto indices not cleared");
  a_stat_read: assert property ( // RL4
    clk_en_i && rd && is_stat
    |=> host_rdata_o == $past(stat_rd[host_addr_i[7:6]]))
    else $error("status read returned wrong entry");
  a_mode_read: assert property ( // RL5
    clk_en_i && rd && host_addr_i == 8'hCD |=> host_rdata_o == mode_o)
    else $error("mode register not at its address");
  a_cfg_bound: assert property ( // RL6
    cfg_idx <= 7'd64 && tbl_idx <= 7'd63 && tally_idx <= 7'd63)
    else $error("auto index out of range");
  a_lock_mode: assert property ( // RL7
    ch_active_i && wr && is_ch0 && rofs == icr_pkg::OFS_MODE
    |=> $stable(mode_o))
    else $error("mode written while channel active");
  a_cfg_lock: assert property ( // RL11
    ch_active_i && wr && hit_cfg && cfg_idx != 7'd0 && !idx_clr
    |=> $stable(cfg_idx))
    else $error("protected setup write took effect");
  a_reset_vals: assert property ( // RL8
    $past(reset_i) |-> mode_o == 8'h92 && scl_low_o == 8'h5E
    && scl_high_o == 8'h3F && repeat_total_o == 8'h01 && cmd_o == 8'h00)
    else $error("reset values wrong");
  a_ptr_range: assert property ( // RL9
    q.ptr <= 13'h10FF)
    else $error("buffer pointer beyond buffer");
  a_tally_step: assert property ( // RL1
    clk_en_i && tally_inc && tally_idx != 7'(icr_pkg::TALLY_DEPTH - 1)
    |=> tally_idx == $past(tally_idx) + 7'd1)
    else $error("tally index did not step");
  a_buf_step: assert property ( // RL1
    clk_en_i && (wr || rd) && hit_buf && q.ptr != icr_pkg::BUF_LAST
    |=> q.ptr == $past(q.ptr) + icr_pkg::BUF_ONE)
    else $error("buffer pointer did not step");
  a_cfg_wrap: assert property ( // RL6
    clk_en_i && cfg_inc && cfg_idx == 7'(icr_pkg::CFG_DEPTH - 1)
    |=> cfg_idx == 7'd0)
    else $error("setup index did not wrap after its last entry");
  a_tbl_lock: assert property ( // RL11
    ch_active_i && wr && hit_tbl |=> $stable(tbl_idx))
    else $error("protected table write moved the index");
  a_stall_lock: assert property ( // RL11
    ch_active_i && wr && is_ch0 && rofs == icr_pkg::OFS_STALL
    |=> $stable(stall_limit_o))
    else $error("stall limit written while channel active");
  a_srst_open: assert property ( // RL7
    clk_en_i && wr && is_ch0 && rofs == icr_pkg::OFS_SRST
    |=> soft_reset_o == $past(host_wdata_i))
    else $error("soft reset register refused a write");
  a_cmd_selfclr: assert property ( // RL3
    cmd_o[icr_pkg::CMD_IDX_CLR_BIT] == 1'b0
    && cmd_o[icr_pkg::CMD_BPTR_CLR_BIT] == 1'b0)
    else $error("pointer clear bits read back set");
  a_state_follow: assert property ( // RL5
    clk_en_i |=> q.state == $past(ch_state_i))
    else $error("channel state not sampled");
  a_dead_page: assert property ( // RL5
    clk_en_i && rd && !is_stat && !is_ch0
    |=> host_rdata_o == icr_pkg::RST_ZERO)
    else $error("unmapped address did not read as zero");

  // ----------------------------------------------------------------
  // coverage
  // ----------------------------------------------------------------

  c_buf_wrap: cover property (hit_buf && rd && q.ptr == 13'h10FF);
  c_lock_drop: cover property (ch_active_i && tbl_we == 1'b0 && wr
    && hit_tbl);
  c_stat_ch2: cover property (rd && host_addr_i[7:6] == 2'h2);
  c_total_active: cover property (ch_active_i && cfg_we);
  c_idx_clear: cover property (clk_en_i && idx_clr);
endmodule // icr_regmap
`default_nettype wire

//--- bench/icr_host_model.sv
// Purpose: host cpu model driving the 8-bit register bus of the block
// Assumes: strobe taken on the rising edge, read data valid after it
// Notes: one access per call, bus released between accesses
`timescale 1ns/1ns
`default_nettype none
module icr_host_model (
  input wire logic sys_clk_i,
  output logic [7:0] host_addr_o,
  output logic host_wr_o,
  output logic host_rd_o,
  output logic [7:0] host_wdata_o,
  input wire logic [7:0] host_rdata_i
);
  initial begin
    host_addr_o = 8'h00;
    host_wr_o = 1'b0;
    host_rd_o = 1'b0;
    host_wdata_o = 8'h00;
  end

  // released lines flip so a stale address or data can never match
  task automatic release_bus();
    host_wr_o = 1'b0;
    host_rd_o = 1'b0;
    host_addr_o = ~host_addr_o;
    host_wdata_o = ~host_wdata_o;
  endtask

  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    #1;
    host_addr_o = a;
    host_wdata_o = d;
    host_wr_o = 1'b1;
    @(posedge sys_clk_i);
    #1;
    release_bus();
  endtask

  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk_i);
    #1;
    host_addr_o = a;
    host_rd_o = 1'b1;
    @(posedge sys_clk_i);
    #1;
    d = host_rdata_i;
    release_bus();
  endtask
endmodule // icr_host_model
`default_nettype wire

//--- bench/tb_top.sv
// Purpose: self-checking bench for the channel register map
// Assumes: host model drives the bus, bench plays the sequencer
// Notes: expected values are built from the register table
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic sys_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic clk_en_i = 1'b1;
  logic ch_active_i = 1'b0;
  logic [7:0] ch_state_i = 8'h00;
  logic stat_wr_i = 1'b0;
  logic [1:0] stat_ch_i = 2'h0;
  logic [5:0] stat_idx_i = 6'h00;
  logic [7:0] stat_val_i = 8'h00;
  logic tally_wr_i = 1'b0;
  logic [5:0] tally_idx_i = 6'h00;
  logic [7:0] tally_val_i = 8'h00;
  logic [7:0] h_addr, h_wdata, h_rdata, cmd, irq, rpt, intv;
  logic [7:0] scl_lo, scl_hi, mode, stall, srst;
  logic h_wr, h_rd;
  int num_errors = 0;
  int num_checks = 0;
  int cycles = 0;
  int i;
  logic [7:0] ra [12] = '{8'hC0, 8'hC1, 8'hC2, 8'hC6, 8'hC7, 8'hC9,
    8'hCA, 8'hCB, 8'hCC, 8'hCD, 8'hCE, 8'hCF};
  logic [7:0] rv [12] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01,
    8'h00, 8'h5E, 8'h3F, 8'h92, 8'h00, 8'h00};
  logic [7:0] wa [8] = '{8'hC2, 8'hC9, 8'hCA, 8'hCB, 8'hCC, 8'hCD,
    8'hCE, 8'hCF};

  always #2 sys_clk_i = ~sys_clk_i;

  icr_host_model hm_u (.sys_clk_i(sys_clk_i), .host_addr_o(h_addr),
    .host_wr_o(h_wr), .host_rd_o(h_rd), .host_wdata_o(h_wdata),
    .host_rdata_i(h_rdata));

  icr_regmap dut_u (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
    .clk_en_i(clk_en_i), .host_addr_i(h_addr), .host_wr_i(h_wr),
    .host_rd_i(h_rd), .host_wdata_i(h_wdata), .host_rdata_o(h_rdata),
    .ch_active_i(ch_active_i), .ch_state_i(ch_state_i),
    .stat_wr_i(stat_wr_i), .stat_ch_i(stat_ch_i), .stat_idx_i(stat_idx_i),
    .stat_val_i(stat_val_i), .tally_wr_i(tally_wr_i),
    .tally_idx_i(tally_idx_i), .tally_val_i(tally_val_i), .cmd_o(cmd),
    .irq_gate_o(irq), .repeat_total_o(rpt), .repeat_interval_o(intv),
    .scl_low_o(scl_lo), .scl_high_o(scl_hi), .mode_o(mode),
    .stall_limit_o(stall), .soft_reset_o(srst));

  task automatic final_report();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    hm_u.read_reg(a, d);
    chk(d, exp);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    hm_u.write_reg(a, d);
  endtask

  task automatic seq_put(input logic t, input logic [1:0] c,
    input logic [5:0] n, input logic [7:0] v);
    @(posedge sys_clk_i);
    #1;
    stat_wr_i = ~t;
    tally_wr_i = t;
    stat_ch_i = c;
    stat_idx_i = n;
    tally_idx_i = n;
    stat_val_i = v;
    tally_val_i = v;
    @(posedge sys_clk_i);
    #1;
    stat_wr_i = 1'b0;
    tally_wr_i = 1'b0;
  endtask

  // a hang costs a mismatch and ends the run through the same report
  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 6000) begin
      num_errors++;
      final_report();
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge sys_clk_i);
    #1;
    reset_i = 1'b0;
    for (i = 0; i < 12; i++) rdc(ra[i], rv[i]);
    chk(scl_hi, 8'h3F);
    rdc(8'h00, 8'h00);
    rdc(8'hBF, 8'h00);
    for (i = 0; i < 8; i++) wr(wa[i], wa[i] ^ 8'h5A);
    for (i = 0; i < 8; i++) rdc(wa[i], wa[i] ^ 8'h5A);
    chk(mode, 8'h97);
    chk(irq, 8'h98);
    chk(rpt, 8'h93);
    chk(intv, 8'h90);
    chk(scl_lo, 8'h91);
    chk(stall, 8'h94);
    chk(srst, 8'h95);
    ch_state_i = 8'hA5;
    wr(8'hC1, 8'h00);
    rdc(8'hC1, 8'hA5);
    wr(8'hD0, 8'hFF);
    rdc(8'hD0, 8'h00);
    ch_active_i = 1'b1;
    for (i = 1; i < 7; i++) wr(wa[i], 8'h00);
    for (i = 1; i < 7; i++) rdc(wa[i], wa[i] ^ 8'h5A);
    wr(8'hC2, 8'h3C);
    rdc(8'hC2, 8'h3C);
    chk(irq, 8'h3C);
    wr(8'hCF, 8'h66);
    chk(srst, 8'h66);
    chk(scl_lo, 8'h91);
    wr(8'hC0, 8'h80);
    wr(8'hC3, 8'h77);
    wr(8'hC4, 8'h2A);
    wr(8'hC4, 8'h2B);
    ch_active_i = 1'b0;
    wr(8'hC3, 8'hE1);
    wr(8'hC4, 8'h2C);
    clk_en_i = 1'b0;
    wr(8'hC9, 8'h00);
    clk_en_i = 1'b1;
    rdc(8'hC9, 8'h93);
    wr(8'hC0, 8'h80);
    rdc(8'hC3, 8'hE1);
    rdc(8'hC4, 8'h2A);
    rdc(8'hC4, 8'h2C);
    wr(8'hC0, 8'h80);
    for (i = 0; i < 64; i++) wr(8'hC3, 8'(i) ^ 8'hA0);
    for (i = 0; i < 65; i++) wr(8'hC4, 8'(i) + 8'h10);
    for (i = 0; i < 64; i++) seq_put(1'b1, 2'h0, 6'(i), 8'(i) + 8'h40);
    wr(8'hC0, 8'h80);
    for (i = 0; i < 64; i++) rdc(8'hC3, 8'(i) ^ 8'hA0);
    rdc(8'hC3, 8'hA0);
    for (i = 0; i < 65; i++) rdc(8'hC4, 8'(i) + 8'h10);
    rdc(8'hC4, 8'h10);
    for (i = 0; i < 64; i++) rdc(8'hC8, 8'(i) + 8'h40);
    rdc(8'hC8, 8'h40);
    // buffer window, written only while idle
    wr(8'hC6, 8'h02);
    wr(8'hC7, 8'h03);
    wr(8'hC5, 8'hAA);
    wr(8'hC5, 8'hBB);
    wr(8'hC6, 8'hFF);
    wr(8'hC7, 8'hFF);
    for (i = 0; i < 17; i++) wr(8'hC5, 8'(i) + 8'hC0);
    wr(8'hC5, 8'h5D);
    wr(8'hC0, 8'hC3);
    chk(cmd, 8'h03);
    rdc(8'hC5, 8'h5D);
    wr(8'hC6, 8'h02);
    wr(8'hC7, 8'h03);
    rdc(8'hC5, 8'hAA);
    rdc(8'hC5, 8'hBB);
    wr(8'hC6, 8'hFF);
    wr(8'hC7, 8'hFF);
    for (i = 0; i < 17; i++) rdc(8'hC5, 8'(i) + 8'hC0);
    rdc(8'hC5, 8'h5D);
    seq_put(1'b0, 2'h0, 6'h00, 8'h11);
    seq_put(1'b0, 2'h1, 6'h3F, 8'h22);
    seq_put(1'b0, 2'h2, 6'h20, 8'h33);
    seq_put(1'b0, 2'h3, 6'h05, 8'h44);
    rdc(8'h00, 8'h11);
    rdc(8'h00, 8'h11);
    rdc(8'h7F, 8'h22);
    rdc(8'hA0, 8'h33);
    rdc(8'h05, 8'h00);
    rdc(8'h85, 8'h00);
    @(posedge sys_clk_i);
    #1;
    reset_i = 1'b1;
    repeat (3) @(posedge sys_clk_i);
    #1;
    reset_i = 1'b0;
    rdc(8'hCD, 8'h92);
    chk(rpt, 8'h01);
    chk(srst, 8'h00);
    chk(irq, 8'h00);
    rdc(8'hC3, 8'h00);
    rdc(8'h00, 8'h00);
    final_report();
  end
endmodule // tb_top
`default_nettype wire
